// ---- verification/sadc_host_model.sv ----
// sadc_host_model: host side of the serial converter link
// assumes: lk is the link clock; tasks are called from the testbench
`timescale 1ns/100ps
`default_nettype none
module sadc_host_model #(
  parameter int HALF = 20  // link cycles per shift clock half period
) (
  input wire logic lk,         // link clock, 15 ns
  output logic shift_clock,    // host shift clock
  output logic cs_n,           // chip select, low active
  output logic din,            // serial data to the device
  input wire logic dout,       // resolved data out pin
  input wire logic busy        // resolved busy pin
);
  logic dq[$];
  logic bq[$];

  // ==========================================================
  // idle levels: shift clock stands still outside frames
  initial begin
    shift_clock = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // an unselected data line toggles so a stale bit never passes
  always @(posedge lk) begin
    if (cs_n) begin
      din <= ~din;
    end
  end

  // ==========================================================
  // one frame: pins sampled just before each rising edge; 600 ns
  // period keeps readout under 2 mhz and sampling window long
  task automatic shift(input logic bits[$]);
    int i;
    dq.delete();
    bq.delete();
    @(posedge lk);
    cs_n <= 1'b0;
    repeat (2 * HALF) @(posedge lk);
    for (i = 0; i < bits.size(); i++) begin
      din <= bits[i];
      repeat (HALF) @(posedge lk);
      dq.push_back(dout);
      bq.push_back(busy);
      shift_clock <= 1'b1;
      repeat (HALF) @(posedge lk);
      shift_clock <= 1'b0;
    end
    repeat (HALF) @(posedge lk);
  endtask : shift

  // end of frame
  task automatic cs_up;
    @(posedge lk);
    cs_n <= 1'b1;
  endtask : cs_up
endmodule : sadc_host_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// tb_top: self-checking bench of the serial converter control block
// assumes: sadc_map.svh on the include path; host model drives the link
`timescale 1ns/100ps
`default_nettype none
`include "sadc_map.svh"
module tb_top;
  logic clk = 1'b0;
  logic lk = 1'b0;
  logic sys_rst = 1'b1;
  logic [`SADC_RES_BITS-1:0] code = '0;
  wire logic sclk, cs_n, din, dout_o, dout_oe_n, busy_o, busy_oe_n;
  wire logic [1:0] mux_pos, mux_neg;
  wire logic mux_com, mux_valid, hold_o, pd_o, int_o;
  wire logic dout_pin = dout_oe_n ? 1'bz : dout_o;
  wire logic busy_pin = busy_oe_n ? 1'bz : busy_o;
  logic bits[$];
  logic [2:0] ch[4] = '{`SADC_CH_A, `SADC_CH_B, `SADC_CH_C, `SADC_CH_D};
  int error_cnt = 0;
  int comparisons = 0;
  int m_int = 0;
  int m_auto = 0;
  int r_int = 0;
  int i;

  // ==========================================================
  // clocks: link clock offset so its edges never meet clk edges
  always #5 clk = ~clk;
  initial begin
    #2.1;
    forever #7.5 lk = ~lk;
  end

  sadc_serial_ctrl u_dut (.clk(clk), .sys_rst(sys_rst),
    .shift_clock(sclk), .cs_n(cs_n), .din(din), .analog_code(code),
    .dout_o(dout_o), .dout_oe_n(dout_oe_n), .busy_o(busy_o),
    .busy_oe_n(busy_oe_n), .mux_pos(mux_pos), .mux_neg(mux_neg),
    .mux_com(mux_com), .mux_valid(mux_valid), .hold_o(hold_o),
    .power_down_o(pd_o), .int_clk_mode_o(int_o));
  sadc_host_model u_host (.lk(lk), .shift_clock(sclk), .cs_n(cs_n),
    .din(din), .dout(dout_pin), .busy(busy_pin));

  // ==========================================================
  // comparison and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // reference model: append a word with leading and trailing zeros
  task automatic add(input logic [7:0] w, input int pre, input int tail);
    int k;
    repeat (pre) bits.push_back(1'b0);
    for (k = 7; k >= 0; k--) bits.push_back(w[k]);
    repeat (tail) bits.push_back(1'b0);
  endtask : add

  // external conversion seen from the word's first rising edge at b;
  // bl is the busy level left by the run before (internal ends high)
  task automatic ext_chk(input int b, input int nz, input int bl);
    int k;
    chk(u_host.bq[b+7], bl);
    chk(u_host.bq[b+8], 1);
    chk(u_host.bq[b+9], 0);
    for (k = 0; k < 16; k++) chk(u_host.dq[b+9+k], code[15-k]);
    for (k = 0; k < nz; k++) chk(u_host.dq[b+25+k], 0);
  endtask : ext_chk

  // one conversion; the path is the clock mode before the word
  task automatic conv(input logic [7:0] w, input int pre);
    int k;
    int n;
    int idx;
    @(posedge clk);
    code <= `SADC_RES_BITS'($urandom());
    bits.delete();
    add(w, pre, m_int ? 0 : 24);
    u_host.shift(bits);
    if (m_int != 0) begin
      chk(busy_o, 0);
      chk(hold_o, 1);
      u_host.cs_up();
      repeat (10) @(posedge clk);
      chk(dout_oe_n, 1);
      n = 0;
      while (busy_o !== 1'b1 && n < 1000) begin
        @(posedge clk);
        n++;
      end
      if (n == 1000) begin
        error_cnt++;
        report_and_stop();
      end
      chk(n <= 800, 1);
      bits.delete();
      repeat (17) bits.push_back(1'b0);
      u_host.shift(bits);
      for (k = 0; k < 16; k++) chk(u_host.dq[k+1], code[15-k]);
    end else begin
      ext_chk(pre, 7, r_int);
    end
    r_int = m_int;
    u_host.cs_up();
    repeat (10) @(posedge clk);
    chk(dout_oe_n, 1);
    chk(busy_oe_n, m_int ? 0 : 1);
    case (w[1:0])
      2'h3: begin
        m_int = 0;
        m_auto = 0;
      end
      2'h2: begin
        m_int = 1;
        m_auto = 0;
      end
      2'h0: m_auto = 1;
      default: ;
    endcase
    for (idx = 0; ch[idx] != w[6:4]; idx++);
    chk(mux_valid, 1);
    chk(mux_pos, idx);
    chk(mux_com, w[2]);
    if (!w[2]) chk(mux_neg, idx ^ 1);
    chk(int_o, m_int);
    chk(pd_o, m_auto);
    $display("test done, word %h", w);
  endtask : conv

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h7292));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(int_o, 0);
    chk(pd_o, 0);
    chk(dout_oe_n, 1);
    // every channel code in both input modes, idle bits before marker
    for (i = 0; i < 8; i++) conv({1'b1, ch[i%4], 1'b1, i < 4, 2'h3}, i % 3);
    // 24 clocks per conversion: next marker on the lsb clock
    @(posedge clk);
    code <= `SADC_RES_BITS'($urandom());
    bits.delete();
    add(8'h9f, 0, 16);
    add(8'hef, 0, 24);
    u_host.shift(bits);
    ext_chk(0, 0, 0);
    ext_chk(24, 7, 0);
    u_host.cs_up();
    repeat (10) @(posedge clk);
    chk(dout_oe_n, 1);
    $display("test done, overlap");
    // clock mode changes and auto power-down
    conv(8'h9e, 0);
    conv(8'hdc, 0);
    conv(8'haf, 1);
    conv(8'he8, 2);
    conv(8'h9f, 0);
    report_and_stop();
  end

  // whole-run limit
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire

// ---- verilog/sadc_map.svh ----
// sadc_map.svh: constants of the serial converter control block
// assumes: included by bare name; widths and codes shared by all files but the host model
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH

// ==========================================================
// control word layout
`define SADC_CW_MARK 7
`define SADC_CH_HI 6
`define SADC_CH_LO 4
`define SADC_CW_ONE 3
`define SADC_CW_MODE 2
`define SADC_PD_HI 1
`define SADC_PD_LO 0
`define SADC_CW_LAST 3'h7
`define SADC_LK_FIRST 3'h1

// ==========================================================
// result and bit counting
`define SADC_RES_BITS 16
`define SADC_CNT_W 5
`define SADC_RES_LAST 5'h0f
`define SADC_RES_DONE 5'h10

// ==========================================================
// power mode codes, channel codes, multiplexer inputs
`define SADC_PD_AUTO 2'h0
`define SADC_PD_INT 2'h2
`define SADC_PD_EXT 2'h3
`define SADC_CH_A 3'h1
`define SADC_CH_B 3'h5
`define SADC_CH_C 3'h2
`define SADC_CH_D 3'h6
`define SADC_IN0 2'h0
`define SADC_IN1 2'h1
`define SADC_IN2 2'h2
`define SADC_IN3 2'h3

// ==========================================================
// timing
`define SADC_CLK_PERIOD_NS 10
`define SADC_BUSY_MAX_NS 8000
`define SADC_BUSY_MAX_CYC (`SADC_BUSY_MAX_NS / `SADC_CLK_PERIOD_NS)
`define SADC_STEP_DIV 20
`define SADC_TMR_W 10

// ==========================================================
// reset values
`define SADC_RST_INT_MODE 1'b0
`define SADC_RST_AUTO_PD 1'b0

`endif

// ---- verilog/sadc_pkg.sv ----
// sadc_pkg: state types of the serial converter control block
// assumes: sadc_map.svh on the include path
`default_nettype none
package sadc_pkg;
  `include "sadc_map.svh"

  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_EXT_ARM = 3'b001,
    S_EXT_DEC = 3'b010,
    S_EXT_OUT = 3'b011,
    S_EXT_ZERO = 3'b100,
    S_INT_CONV = 3'b101,
    S_INT_DONE = 3'b110
  } sadc_state_t;

  // ==========================================================
  // link side: control word receiver on the shift clock
  typedef struct packed {
    logic active;
    logic [2:0] cnt;
    logic [6:0] sh;
    logic [7:0] word;
    logic req;
  } sadc_link_t;

  // ==========================================================
  // system side: sequencer, synchronisers and pin registers
  typedef struct packed {
    logic sclk_s1, sclk_s2, sclk_s3;
    logic cs_s1, cs_s2;
    logic req_s1, req_s2, req_s3;
    logic [`SADC_RES_BITS-1:0] code_s1, code_s2;
    sadc_state_t state;
    logic int_mode, auto_pd, run_int;
    logic [`SADC_CNT_W-1:0] cnt;
    logic [`SADC_TMR_W-1:0] tmr;
    logic [`SADC_RES_BITS-1:0] result;
    logic dout, dout_oe_n, busy, busy_oe_n;
    logic [1:0] mux_pos, mux_neg;
    logic mux_com, mux_valid, hold, pwr_down;
    logic eng_start, eng_step;
  } sadc_core_t;
endpackage : sadc_pkg
`default_nettype wire

// ---- verilog/sadc_sar_step.sv ----
// sadc_sar_step: successive-approximation register, one decision a step
// assumes: start and step come from logic on the same clock
`default_nettype none
`timescale 1ns/100ps
`include "sadc_map.svh"
module sadc_sar_step #(
  parameter int unsigned RES_W = `SADC_RES_BITS
) (
  input wire logic clk,                  // system clock
  input wire logic sys_rst,              // synchronous reset
  input wire logic start,                // capture sample, clear result
  input wire logic step,                 // decide the next bit
  input wire logic [RES_W-1:0] sample,   // held input code
  output logic bit_o,                    // latest decided bit
  output logic [RES_W-1:0] result_o      // bits decided so far
);
  import sadc_pkg::*;

  typedef struct packed {
    logic [RES_W-1:0] sample, result, mask;
    logic bit_d;
  } sadc_sar_t;

  sadc_sar_t st_ff, nxt_st;

  // ==========================================================
  // one trial per step, msb first; an exhausted mask ignores steps
  always_comb begin
    nxt_st = st_ff;
    if (start) begin
      nxt_st.sample = sample;
      nxt_st.result = '0;
      nxt_st.mask = {1'b1, {(RES_W-1){1'b0}}};
    end else if (step && (|st_ff.mask)) begin
      nxt_st.bit_d = (st_ff.sample >= (st_ff.result | st_ff.mask));
      if (nxt_st.bit_d) begin
        nxt_st.result = st_ff.result | st_ff.mask;
      end
      nxt_st.mask = st_ff.mask >> 1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bit_o = st_ff.bit_d;
  assign result_o = st_ff.result;

  // ==========================================================
  // checks
  a_start_msb: assert property (@(posedge clk) disable iff (sys_rst)
    start |=> (st_ff.mask[RES_W-1] && st_ff.result == '0)) // RQ13
    else $error("start did not arm the msb trial");
endmodule : sadc_sar_step
`default_nettype wire

// ---- verilog/sadc_serial_ctrl.sv ----
// sadc_serial_ctrl: serial control and readout of a 4-input 16-bit sar
// assumes: host drives cs_n, din and shift_clock; analog_code is the
//   converter front end's code, quasi-static, from outside this clock
//
// Contract
// (RQ1) ignore din until first high marker bit
// (RQ2) eight bit word: marker, channel, one, mode, power
// (RQ3) mode high: input against common; low: pair
// (RQ4) power bits 11: always on, external clock
// (RQ5) power bits 00: sleep after conversion, instant wake
// (RQ6) power bits 10: internal conversion clock
// (RQ7) host never writes power bits 01
// (RQ8) clock mode change applies one conversion later
// (RQ9) host sets clock mode before auto sleep
// (RQ10) auto sleep keeps the previous clock mode
// (RQ11) shift clock moves every serial bit
// (RQ12) external: busy high one period after word
// (RQ13) external: sixteen result bits, msb first
// (RQ14) host may overlap next word with lsb
// (RQ15) 32-clock frames: zeros after the result
// (RQ16) external: outputs float while cs high
// (RQ17) internal: busy low during conversion, max 8us
// (RQ18) internal: result held until read, slow clock
// (RQ19) host keeps shift clock low while converting
// (RQ20) internal: msb at first fall after completion
// (RQ21) internal: dout floats until cs low; busy driven
// (RQ22) fast shifting needs enough sampling window time
// (RQ23) channel codes pick inputs and pairs
// (RQ24) din taken on rise, dout changes on fall
`default_nettype none
`timescale 1ns/100ps
`include "sadc_map.svh"
module sadc_serial_ctrl #(
  parameter int unsigned INT_STEP_CYC =
    `SADC_BUSY_MAX_CYC / `SADC_STEP_DIV
) (
  input wire logic clk,                  // system clock, 100 mhz
  input wire logic sys_rst,              // synchronous reset, high
  input wire logic shift_clock,          // host shift clock
  input wire logic cs_n,                 // chip select, low active
  input wire logic din,                  // serial data in
  input wire logic [`SADC_RES_BITS-1:0] analog_code, // front end code
  output logic dout_o,                   // serial data out
  output logic dout_oe_n,                // dout driven when low
  output logic busy_o,                   // busy level
  output logic busy_oe_n,                // busy driven when low
  output logic [1:0] mux_pos,            // positive input select
  output logic [1:0] mux_neg,            // negative input select
  output logic mux_com,                  // negative input is common
  output logic mux_valid,                // channel code recognised
  output logic hold_o,                   // sample held, converting
  output logic power_down_o,             // low power between runs
  output logic int_clk_mode_o            // internal clock mode chosen
);
  import sadc_pkg::*;

  localparam logic [`SADC_TMR_W-1:0] STEP_LAST =
    `SADC_TMR_W'(INT_STEP_CYC - 1);
  localparam int BUSY_MAX = `SADC_BUSY_MAX_CYC;

  sadc_link_t lk_ff, nxt_lk;
  sadc_core_t st_ff, nxt_st;
  logic sclk_fall;
  logic word_evt;
  logic [7:0] cw;
  logic eng_bit;
  logic [`SADC_RES_BITS-1:0] eng_res;

  // ==========================================================
  // link side: hunt for the marker, then take seven more bits
  // on rising edges; the word stays put while req is high
  always_comb begin
    nxt_lk = lk_ff;
    if (!lk_ff.active) begin
      if (din) begin                                         // RQ1
        nxt_lk.active = 1'b1;
        nxt_lk.cnt = `SADC_LK_FIRST;
        nxt_lk.sh = 7'h01;
        nxt_lk.req = 1'b0;
      end
    end else begin
      nxt_lk.sh = {lk_ff.sh[5:0], din};                      // RQ24
      nxt_lk.cnt = lk_ff.cnt + 3'h1;
      if (lk_ff.cnt == `SADC_CW_LAST) begin                  // RQ2
        nxt_lk.word = {lk_ff.sh, din};
        nxt_lk.req = 1'b1;
        nxt_lk.active = 1'b0;
      end
    end
  end

  // cs high clears the receiver even with the shift clock stopped
  always_ff @(posedge shift_clock or posedge cs_n) begin     // RQ11
    if (cs_n) begin
      lk_ff <= '0;
    end else begin
      lk_ff <= nxt_lk;
    end
  end

  // ==========================================================
  // event detection on synchronised copies
  assign sclk_fall = st_ff.sclk_s3 & ~st_ff.sclk_s2 & ~st_ff.cs_s2;
  assign word_evt = st_ff.req_s2 & ~st_ff.req_s3;
  assign cw = lk_ff.word;

  // ==========================================================
  // sequencer: external runs step on shift clock falls, internal
  // runs step on a timer; a new word always restarts the sequence
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sclk_s1 = shift_clock;
    nxt_st.sclk_s2 = st_ff.sclk_s1;
    nxt_st.sclk_s3 = st_ff.sclk_s2;
    nxt_st.cs_s1 = cs_n;
    nxt_st.cs_s2 = st_ff.cs_s1;
    nxt_st.req_s1 = lk_ff.req;
    nxt_st.req_s2 = st_ff.req_s1;
    nxt_st.req_s3 = st_ff.req_s2;
    nxt_st.code_s1 = analog_code;
    nxt_st.code_s2 = st_ff.code_s1;
    nxt_st.eng_start = 1'b0;
    nxt_st.eng_step = 1'b0;
    case (st_ff.state)
      S_IDLE: begin
        nxt_st.busy = st_ff.run_int ? st_ff.busy : 1'b0;     // RQ16
      end
      S_EXT_ARM: begin
        if (sclk_fall) begin
          nxt_st.busy = 1'b1;                                // RQ12
          nxt_st.eng_start = 1'b1;
          nxt_st.hold = 1'b1;
          nxt_st.state = S_EXT_DEC;
        end
      end
      S_EXT_DEC: begin
        // msb decision made while busy is high
        nxt_st.eng_step = 1'b1;
        nxt_st.cnt = '0;
        nxt_st.state = S_EXT_OUT;
      end
      S_EXT_OUT: begin
        if (sclk_fall) begin
          nxt_st.busy = 1'b0;                                // RQ12
          nxt_st.dout = eng_bit;                             // RQ13
          nxt_st.eng_step = 1'b1;
          if (st_ff.cnt == `SADC_RES_LAST) begin
            nxt_st.state = S_EXT_ZERO;
            nxt_st.hold = 1'b0;
            nxt_st.pwr_down = st_ff.auto_pd;                 // RQ5
          end else begin
            nxt_st.cnt = st_ff.cnt + 5'h01;
          end
        end
      end
      S_EXT_ZERO: begin
        if (sclk_fall) begin
          nxt_st.dout = 1'b0;                                // RQ15
        end
      end
      S_INT_CONV: begin
        if (st_ff.tmr == STEP_LAST) begin                    // RQ6
          nxt_st.tmr = '0;
          if (st_ff.cnt == `SADC_RES_DONE) begin
            nxt_st.result = eng_res;                         // RQ18
            nxt_st.busy = 1'b1;                              // RQ17
            nxt_st.cnt = '0;
            nxt_st.hold = 1'b0;
            nxt_st.pwr_down = st_ff.auto_pd;                 // RQ5
            nxt_st.state = S_INT_DONE;
          end else begin
            nxt_st.eng_step = 1'b1;
            nxt_st.cnt = st_ff.cnt + 5'h01;
          end
        end else begin
          nxt_st.tmr = st_ff.tmr + 10'h001;
        end
      end
      S_INT_DONE: begin
        // readout waits for cs low; falls then walk msb to lsb
        if (sclk_fall) begin                                 // RQ20
          if (st_ff.cnt != `SADC_RES_DONE) begin
            nxt_st.dout = st_ff.result[4'(`SADC_RES_LAST - st_ff.cnt)];
            nxt_st.cnt = st_ff.cnt + 5'h01;
          end else begin
            nxt_st.dout = 1'b0;
          end
        end
      end
      default: begin
        nxt_st.state = S_IDLE;
      end
    endcase
    // cs high ends an external frame; an internal run carries on
    if (st_ff.cs_s2 && !st_ff.run_int &&
        st_ff.state != S_IDLE) begin                         // RQ16
      nxt_st.state = S_IDLE;
      nxt_st.busy = 1'b0;
      nxt_st.hold = 1'b0;
    end
    if (word_evt) begin
      nxt_st.mux_com = cw[`SADC_CW_MODE];                    // RQ3
      nxt_st.mux_valid = 1'b1;
      case (cw[`SADC_CH_HI:`SADC_CH_LO])                     // RQ23
        `SADC_CH_A: begin
          nxt_st.mux_pos = `SADC_IN0;
          nxt_st.mux_neg = `SADC_IN1;
        end
        `SADC_CH_B: begin
          nxt_st.mux_pos = `SADC_IN1;
          nxt_st.mux_neg = `SADC_IN0;
        end
        `SADC_CH_C: begin
          nxt_st.mux_pos = `SADC_IN2;
          nxt_st.mux_neg = `SADC_IN3;
        end
        `SADC_CH_D: begin
          nxt_st.mux_pos = `SADC_IN3;
          nxt_st.mux_neg = `SADC_IN2;
        end
        default: begin
          nxt_st.mux_valid = 1'b0;
        end
      endcase
      // this word converts in the mode already in effect
      nxt_st.run_int = st_ff.int_mode;                       // RQ8
      case (cw[`SADC_PD_HI:`SADC_PD_LO])
        `SADC_PD_EXT: begin                                  // RQ4
          nxt_st.int_mode = 1'b0;
          nxt_st.auto_pd = 1'b0;
        end
        `SADC_PD_INT: begin                                  // RQ6
          nxt_st.int_mode = 1'b1;
          nxt_st.auto_pd = 1'b0;
        end
        `SADC_PD_AUTO: begin                                 // RQ10
          nxt_st.auto_pd = 1'b1;
        end
        default: begin
          // reserved code: settings left as they were
        end
      endcase
      nxt_st.pwr_down = 1'b0;                                // RQ5
      nxt_st.busy = 1'b0;
      nxt_st.cnt = '0;
      nxt_st.tmr = '0;
      if (st_ff.int_mode) begin
        nxt_st.state = S_INT_CONV;                           // RQ17
        nxt_st.eng_start = 1'b1;
        nxt_st.hold = 1'b1;
      end else begin
        nxt_st.state = S_EXT_ARM;
        nxt_st.hold = 1'b0;
      end
    end
    // the register lag of cs keeps both enables aligned
    nxt_st.dout_oe_n = st_ff.cs_s2;                          // RQ21
    nxt_st.busy_oe_n = nxt_st.run_int ? 1'b0 : st_ff.cs_s2;  // RQ16
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.cs_s1 <= 1'b1;
      st_ff.cs_s2 <= 1'b1;
      st_ff.dout_oe_n <= 1'b1;
      st_ff.busy_oe_n <= 1'b1;
      st_ff.int_mode <= `SADC_RST_INT_MODE;
      st_ff.auto_pd <= `SADC_RST_AUTO_PD;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // bit decisions against the held code
  sadc_sar_step #(.RES_W(`SADC_RES_BITS)) u_sar (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(st_ff.eng_start),
    .step(st_ff.eng_step),
    .sample(st_ff.code_s2),
    .bit_o(eng_bit),
    .result_o(eng_res)
  );

  // ==========================================================
  // pins and status straight from registers
  assign dout_o = st_ff.dout;
  assign dout_oe_n = st_ff.dout_oe_n;
  assign busy_o = st_ff.busy;
  assign busy_oe_n = st_ff.busy_oe_n;
  assign mux_pos = st_ff.mux_pos;
  assign mux_neg = st_ff.mux_neg;
  assign mux_com = st_ff.mux_com;
  assign mux_valid = st_ff.mux_valid;
  assign hold_o = st_ff.hold;
  assign power_down_o = st_ff.pwr_down;
  assign int_clk_mode_o = st_ff.int_mode;

  // ==========================================================
  // checks
  a_marker_hunt: assert property (@(posedge shift_clock)
    disable iff (cs_n) (!lk_ff.active && !din) |=> !lk_ff.active) // RQ1
    else $error("receiver left hunting without a marker");
  a_ext_busy_rise: assert property (@(posedge clk) disable iff (sys_rst)
    (st_ff.state == S_EXT_ARM && sclk_fall && !st_ff.cs_s2)
      |=> st_ff.busy) // RQ12
    else $error("busy not raised after the word");
  a_ext_busy_drop: assert property (@(posedge clk) disable iff (sys_rst)
    (st_ff.state == S_EXT_OUT && sclk_fall && st_ff.cnt == '0 &&
     !st_ff.cs_s2) |=> !st_ff.busy ##1 !st_ff.busy) // RQ12
    else $error("busy longer than one shift period");
  a_ext_bit_out: assert property (@(posedge clk) disable iff (sys_rst)
    (st_ff.state == S_EXT_OUT && sclk_fall && !st_ff.cs_s2)
      |=> st_ff.dout == $past(eng_bit)) // RQ13
    else $error("dout does not carry the decided bit");
  a_zero_tail: assert property (@(posedge clk) disable iff (sys_rst)
    (st_ff.state == S_EXT_ZERO && sclk_fall && !st_ff.cs_s2 &&
     !word_evt) |=> !st_ff.dout) // RQ15
    else $error("dout not zero after the result");
  a_dout_float: assert property (@(posedge clk) disable iff (sys_rst)
    st_ff.dout_oe_n == $past(st_ff.cs_s2)) // RQ21
    else $error("dout enable does not follow cs");
  a_ext_busy_float: assert property (@(posedge clk) disable iff (sys_rst)
    (!st_ff.run_int && $past(st_ff.cs_s2)) |-> st_ff.busy_oe_n) // RQ16
    else $error("busy driven while cs high");
  a_int_busy_drv: assert property (@(posedge clk) disable iff (sys_rst)
    st_ff.run_int |-> !st_ff.busy_oe_n) // RQ21
    else $error("busy floated in internal mode");
  a_int_busy_max: assert property (@(posedge clk) disable iff (sys_rst)
    (word_evt && st_ff.int_mode) |-> ##[1:BUSY_MAX]
      (st_ff.busy || word_evt || st_ff.state != S_INT_CONV)) // RQ17
    else $error("internal conversion too long");
  a_mode_deferred: assert property (@(posedge clk) disable iff (sys_rst)
    word_evt |=> (st_ff.run_int == $past(st_ff.int_mode) &&
      !st_ff.pwr_down)) // RQ8
    else $error("clock mode switched without the extra cycle");
  a_int_msb: assert property (@(posedge clk) disable iff (sys_rst)
    (st_ff.state == S_INT_DONE && sclk_fall && st_ff.cnt == '0 &&
     !word_evt) |=> st_ff.dout == $past(st_ff.result[15])) // RQ20
    else $error("internal readout did not open with the msb");

  c_ext_tail: cover property (@(posedge clk) disable iff (sys_rst)
    st_ff.state == S_EXT_ZERO && sclk_fall);
  c_int_done: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(st_ff.busy) && st_ff.run_int);
  c_mode_swap: cover property (@(posedge clk) disable iff (sys_rst)
    word_evt && st_ff.int_mode != st_ff.run_int);
  c_auto_sleep: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(st_ff.pwr_down));
endmodule : sadc_serial_ctrl
`default_nettype wire
